// ===== common/uart_map.svh
`ifndef UART_MAP_SVH
`define UART_MAP_SVH
// register indices, byte address is four times the index
`define IDX_DATA 3'h0
`define IDX_IER 3'h1
`define IDX_IDENT 3'h2
`define IDX_FMT 3'h3
`define IDX_LSR 3'h5
`define IDX_MSR 3'h6
// frame_format fields
`define FMT_STOP 2
`define FMT_PEN 3
`define FMT_EPS 4
`define FMT_DLA 7
// fifo_setup fields
`define FS_EN 0
`define FS_RXCLR 1
`define FS_TXCLR 2
`define FS_TRIG_HI 7
`define FS_TRIG_LO 6
// interrupt enable fields
`define IER_RDA 0
`define IER_THRE 1
`define IER_LINE 2
`define IER_MS 3
// reset values
`define FMT_RST 8'h00
`define IER_RST 4'h0
`define DIV_RST 16'h0001
`define TRIG_RST 2'h0
// identification codes
`define IID_NONE 4'h1
`define IID_LINE 4'h6
`define IID_RDA 4'h4
`define IID_TO 4'hC
`define IID_THRE 4'h2
`define IID_MODEM 4'h0
// timing counts
`define TIMEOUT_CHARS 4
`define OVS_MID 6'h07
`define OVS_LAST 6'h0F
`endif

// ===== common/uart_pkg.sv
package uart_pkg;
  `include "uart_map.svh"
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_HOLD} rx_state_t;

  function automatic logic [3:0] word_bits(input logic [1:0] wl);
    return 4'h5 + {2'h0, wl};
  endfunction

  function automatic logic parity_bit(input logic [7:0] d, input logic [1:0] wl,
                                      input logic even);
    return (^(d & (8'hFF >> (2'h3 - wl)))) ^ ~even;
  endfunction

  // oversample ticks of the stop period
  function automatic logic [5:0] stop_ticks(input logic [1:0] wl, input logic two);
    if (!two)
      return 6'h10;
    return (wl == 2'h0) ? 6'h18 : 6'h20;
  endfunction
endpackage

// ===== hdl/uart_tx.sv
module uart_tx (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick16,
  input  wire logic [1:0] wlen,
  input  wire logic       stop2,
  input  wire logic       par_en,
  input  wire logic       even_par,
  input  wire logic       load,
  input  wire logic [7:0] load_data,
  output logic            busy,
  output logic            txd
);
  import uart_pkg::*;
  tx_state_t   state_r;
  logic [7:0]  shift_r;
  logic [5:0]  tick_r;
  logic [2:0]  bit_r;
  logic        par_r;
  logic        bit_end;

  assign busy = (state_r != TX_IDLE);
  assign bit_end = tick_r == ((state_r == TX_STOP) ? stop_ticks(wlen, stop2) - 6'h01
                                                   : `OVS_LAST);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= TX_IDLE;
      shift_r <= 8'h00;
      tick_r  <= 6'h00;
      bit_r   <= 3'h0;
      par_r   <= 1'b0;
    end
    else if (load && state_r == TX_IDLE)
    begin
      state_r <= TX_START;
      shift_r <= load_data;
      tick_r  <= 6'h00;
      bit_r   <= 3'h0;
      par_r   <= parity_bit(load_data, wlen, even_par);
    end
    else if (tick16 && busy)
    begin
      tick_r <= bit_end ? 6'h00 : tick_r + 6'h01;
      if (bit_end)
        unique case (state_r)
          TX_IDLE:  state_r <= TX_IDLE;
          TX_START: state_r <= TX_DATA;
          TX_DATA:
          begin
            shift_r <= {1'b0, shift_r[7:1]};
            bit_r   <= bit_r + 3'h1;
            if ({1'b0, bit_r} == word_bits(wlen) - 4'h1)
              state_r <= par_en ? TX_PAR : TX_STOP;
          end
          TX_PAR:   state_r <= TX_STOP;
          TX_STOP:  state_r <= TX_IDLE;
        endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      txd <= 1'b1;
    else
      txd <= (state_r == TX_START) ? 1'b0 :
             (state_r == TX_DATA)  ? shift_r[0] :
             (state_r == TX_PAR)   ? par_r : 1'b1;
  end
endmodule

// ===== hdl/uart_rx.sv
module uart_rx (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick16,
  input  wire logic       rxd,
  input  wire logic [1:0] wlen,
  input  wire logic       par_en,
  input  wire logic       even_par,
  output logic            valid,
  output logic [7:0]      data,
  output logic            par_err,
  output logic            frm_err,
  output logic            brk
);
  import uart_pkg::*;
  rx_state_t   state_r;
  logic [5:0]  tick_r;
  logic [2:0]  bit_r;
  logic [7:0]  sh_r;
  logic        par_r;
  logic        mid;

  assign mid = tick16 && tick_r == ((state_r == RX_START) ? `OVS_MID : `OVS_LAST);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= RX_IDLE;
      tick_r  <= 6'h00;
      bit_r   <= 3'h0;
      sh_r    <= 8'h00;
      par_r   <= 1'b0;
      valid   <= 1'b0;
      data    <= 8'h00;
      par_err <= 1'b0;
      frm_err <= 1'b0;
      brk     <= 1'b0;
    end
    else
    begin
      valid <= 1'b0;
      if (tick16)
        tick_r <= mid ? 6'h00 : tick_r + 6'h01;
      unique case (state_r)
        RX_IDLE:
        begin
          tick_r <= 6'h00;
          bit_r  <= 3'h0;
          sh_r   <= 8'h00;
          if (!rxd)
            state_r <= RX_START;
        end
        RX_START: if (mid) state_r <= rxd ? RX_IDLE : RX_DATA;
        RX_DATA:
          if (mid)
          begin
            sh_r[bit_r] <= rxd;
            bit_r <= bit_r + 3'h1;
            if ({1'b0, bit_r} == word_bits(wlen) - 4'h1)
              state_r <= par_en ? RX_PAR : RX_STOP;
          end
        RX_PAR:
          if (mid)
          begin
            par_r   <= rxd;
            state_r <= RX_STOP;
          end
        RX_STOP:
          if (mid)
          begin
            valid   <= 1'b1;
            data    <= sh_r;
            par_err <= par_en && (par_r != parity_bit(sh_r, wlen, even_par));
            frm_err <= !rxd;
            brk     <= !rxd && sh_r == 8'h00 && !(par_en && par_r);
            state_r <= rxd ? RX_IDLE : RX_HOLD;
          end
        RX_HOLD:  if (rxd) state_r <= RX_IDLE;
      endcase
    end
  end
endmodule

// ===== hdl/uart_irq_fifo_line_format.sv
// Our own choice: register access over APB.
module uart_irq_fifo_line_format #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [4:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        modem_change,
  input  wire logic [7:0]  modem_status,
  output logic             irq_pending
);
  import uart_pkg::*;
  localparam int PW = $clog2(FIFO_DEPTH);

  // ****************************************
  // bus decode
  // ****************************************
  logic [2:0]  idx;
  logic        setup;
  logic        acc_rd;
  logic        acc_wr;
  logic        dla;
  logic        data_rd;
  logic        data_wr;
  logic        ier_wr;
  logic        div_lo_wr;
  logic        div_hi_wr;
  logic        setup_wr;
  logic        fmt_wr;
  logic        lsr_rd;
  logic        msr_rd;
  logic        ident_rd;
  logic [7:0]  fmt_r;
  logic [3:0]  ier_r;
  logic [15:0] div_r;
  logic        fifo_en_r;
  logic [1:0]  trig_r;
  logic [31:0] prdata_r;

  assign idx    = paddr[4:2];
  assign setup  = psel && !penable;
  assign acc_rd = psel && penable && !pwrite;
  assign acc_wr = psel && penable && pwrite;
  assign dla    = fmt_r[`FMT_DLA];
  assign data_rd   = acc_rd && idx == `IDX_DATA && !dla;
  assign data_wr   = acc_wr && idx == `IDX_DATA && !dla;
  assign ier_wr    = acc_wr && idx == `IDX_IER && !dla;
  assign div_lo_wr = acc_wr && idx == `IDX_DATA && dla;
  assign div_hi_wr = acc_wr && idx == `IDX_IER && dla;
  assign setup_wr  = acc_wr && idx == `IDX_IDENT;
  assign ident_rd  = acc_rd && idx == `IDX_IDENT;
  assign fmt_wr    = acc_wr && idx == `IDX_FMT;
  assign lsr_rd    = acc_rd && idx == `IDX_LSR;
  assign msr_rd    = acc_rd && idx == `IDX_MSR;
  assign pready    = 1'b1;
  assign pslverr   = 1'b0;
  assign prdata    = prdata_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fmt_r     <= `FMT_RST;
      ier_r     <= `IER_RST;
      div_r     <= `DIV_RST;
      fifo_en_r <= 1'b0;
      trig_r    <= `TRIG_RST;
    end
    else
    begin
      if (fmt_wr)
        fmt_r <= pwdata[7:0];
      if (ier_wr)
        ier_r <= pwdata[3:0];
      if (div_lo_wr)
        div_r[7:0] <= pwdata[7:0];
      if (div_hi_wr)
        div_r[15:8] <= pwdata[7:0];
      if (setup_wr)
      begin
        fifo_en_r <= pwdata[`FS_EN];
        if (pwdata[`FS_EN])
          trig_r <= pwdata[`FS_TRIG_HI:`FS_TRIG_LO];
      end
    end
  end

  // ****************************************
  // baud tick and serial engines
  // ****************************************
  logic [15:0] div_cnt_r;
  logic        tick16;
  logic        tx_busy;
  logic        tx_pop;
  logic        tx_pop_q_r;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_par;
  logic        rx_frm;
  logic        rx_brk;
  logic [7:0]  tx_mem [FIFO_DEPTH];
  logic [10:0] rx_mem [FIFO_DEPTH];

  assign tick16 = (div_cnt_r == 16'h0000);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt_r <= 16'h0000;
    else if (tick16)
      div_cnt_r <= (div_r == 16'h0000) ? 16'h0000 : div_r - 16'h0001;
    else
      div_cnt_r <= div_cnt_r - 16'h0001;
  end

  logic [PW-1:0] tx_wp_r;
  logic [PW-1:0] tx_rp_r;
  logic [PW-1:0] rx_wp_r;
  logic [PW-1:0] rx_rp_r;
  logic [PW:0]   tx_cnt_r;
  logic [PW:0]   rx_cnt_r;
  logic [PW:0]   cap;
  logic          tx_clr;
  logic          rx_clr;
  logic          tx_push;
  logic          rx_push;
  logic          rx_pop;
  logic          overrun;

  uart_tx u_tx (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick16    (tick16),
    .wlen      (fmt_r[1:0]),
    .stop2     (fmt_r[`FMT_STOP]),
    .par_en    (fmt_r[`FMT_PEN]),
    .even_par  (fmt_r[`FMT_EPS]),
    .load      (tx_pop),
    .load_data (tx_mem[tx_rp_r]),
    .busy      (tx_busy),
    .txd       (txd)
  );

  uart_rx u_rx (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick16    (tick16),
    .rxd       (rxd),
    .wlen      (fmt_r[1:0]),
    .par_en    (fmt_r[`FMT_PEN]),
    .even_par  (fmt_r[`FMT_EPS]),
    .valid     (rx_valid),
    .data      (rx_data),
    .par_err   (rx_par),
    .frm_err   (rx_frm),
    .brk       (rx_brk)
  );

  // ****************************************
  // transmit and receive fifos
  // ****************************************
  // one-deep when fifos disabled
  assign cap = fifo_en_r ? (PW+1)'(FIFO_DEPTH) : (PW+1)'(1);
  assign tx_clr  = setup_wr && (!pwdata[`FS_EN] || pwdata[`FS_TXCLR]);
  assign rx_clr  = setup_wr && (!pwdata[`FS_EN] || pwdata[`FS_RXCLR]);
  assign tx_push = data_wr && tx_cnt_r < cap;
  assign tx_pop  = tx_cnt_r != '0 && !tx_busy && !tx_pop_q_r;
  assign rx_push = rx_valid && rx_cnt_r < cap;
  assign overrun = rx_valid && rx_cnt_r >= cap;
  assign rx_pop  = data_rd && rx_cnt_r != '0;

  always_ff @(posedge pclk)
  begin
    if (tx_push)
      tx_mem[tx_wp_r] <= pwdata[7:0];
    if (rx_push)
      rx_mem[rx_wp_r] <= {rx_brk, rx_frm, rx_par, rx_data};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_wp_r    <= '0;
      tx_rp_r    <= '0;
      tx_cnt_r   <= '0;
      tx_pop_q_r <= 1'b0;
    end
    else
    begin
      tx_pop_q_r <= tx_pop;
      if (tx_clr)
      begin
        tx_wp_r  <= '0;
        tx_rp_r  <= '0;
        tx_cnt_r <= '0;
      end
      else
      begin
        tx_wp_r  <= tx_wp_r + PW'(tx_push);
        tx_rp_r  <= tx_rp_r + PW'(tx_pop);
        tx_cnt_r <= tx_cnt_r + (PW+1)'(tx_push) - (PW+1)'(tx_pop);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_wp_r  <= '0;
      rx_rp_r  <= '0;
      rx_cnt_r <= '0;
    end
    else if (rx_clr)
    begin
      rx_wp_r  <= '0;
      rx_rp_r  <= '0;
      rx_cnt_r <= '0;
    end
    else
    begin
      rx_wp_r  <= rx_wp_r + PW'(rx_push);
      rx_rp_r  <= rx_rp_r + PW'(rx_pop);
      rx_cnt_r <= rx_cnt_r + (PW+1)'(rx_push) - (PW+1)'(rx_pop);
    end
  end

  // ****************************************
  // interrupt sources
  // ****************************************
  logic [3:0]  err_r;
  logic [3:0]  new_err;
  logic        thre_r;
  logic        ms_r;
  logic        to_r;
  logic [10:0] to_cnt_r;
  logic [10:0] to_lim;
  logic        rda_lvl;
  logic [7:0]  ident_now;
  logic [3:0]  iid;
  logic [7:0]  lsr;
  logic [7:0]  rd_mux;

  function automatic logic [PW:0] trig_bytes(input logic [1:0] t);
    unique case (t)
      2'h0: return (PW+1)'(1);
      2'h1: return (PW+1)'(4);
      2'h2: return (PW+1)'(8);
      2'h3: return (PW+1)'(14);
    endcase
  endfunction

  function automatic logic [10:0] to_limit(input logic [7:0] f);
    logic [10:0] nbits;
    nbits = 11'(word_bits(f[1:0])) + 11'h001 + 11'(f[`FMT_PEN]);
    return 11'(`TIMEOUT_CHARS) * ((nbits << 4) + 11'(stop_ticks(f[1:0], f[`FMT_STOP])));
  endfunction

  assign new_err = {rx_valid && rx_brk, rx_valid && rx_frm, rx_valid && rx_par, overrun};
  assign to_lim  = to_limit(fmt_r);
  assign rda_lvl = fifo_en_r ? (rx_cnt_r >= trig_bytes(trig_r)) : (rx_cnt_r != '0);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err_r  <= 4'h0;
      thre_r <= 1'b0;
      ms_r   <= 1'b0;
    end
    else
    begin
      err_r <= (err_r & ~(lsr_rd ? prdata_r[4:1] : 4'h0)) | new_err;
      ms_r  <= modem_change || (ms_r && !msr_rd);
      thre_r <= (tx_pop && tx_cnt_r == (PW+1)'(1) && !tx_push) || tx_clr ||
                (ier_wr && pwdata[`IER_THRE] && !ier_r[`IER_THRE] && tx_cnt_r == '0) ||
                (thre_r && !data_wr && !(ident_rd && prdata_r[3:0] == `IID_THRE));
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      to_cnt_r <= 11'h000;
      to_r     <= 1'b0;
    end
    else
    begin
      if (rx_push || rx_pop || rx_clr || rx_cnt_r == '0 || !fifo_en_r)
        to_cnt_r <= 11'h000;
      else if (tick16 && to_cnt_r < to_lim)
        to_cnt_r <= to_cnt_r + 11'h001;
      if (rx_pop || rx_clr || !fifo_en_r)
        to_r <= 1'b0;
      else if (to_cnt_r >= to_lim && rx_cnt_r != '0)
        to_r <= 1'b1;
    end
  end

  always_comb
  begin
    if (ier_r[`IER_LINE] && err_r != 4'h0)
      iid = `IID_LINE;
    else if (ier_r[`IER_RDA] && rda_lvl)
      iid = `IID_RDA;
    else if (ier_r[`IER_RDA] && to_r)
      iid = `IID_TO;
    else if (ier_r[`IER_THRE] && thre_r)
      iid = `IID_THRE;
    else if (ier_r[`IER_MS] && ms_r)
      iid = `IID_MODEM;
    else
      iid = `IID_NONE;
  end

  // enable mirrors, bits four and five zero
  assign ident_now   = {fifo_en_r, fifo_en_r, 2'h0, iid};
  assign irq_pending = !iid[0];
  assign lsr = {1'b0, tx_cnt_r == '0 && !tx_busy, tx_cnt_r == '0, err_r, rx_cnt_r != '0};

  always_comb
  begin
    unique case (idx)
      `IDX_DATA:  rd_mux = dla ? div_r[7:0] : rx_mem[rx_rp_r][7:0];
      `IDX_IER:   rd_mux = dla ? div_r[15:8] : {4'h0, ier_r};
      `IDX_IDENT: rd_mux = ident_now;
      `IDX_FMT:   rd_mux = fmt_r;
      `IDX_LSR:   rd_mux = lsr;
      `IDX_MSR:   rd_mux = modem_status;
      default:    rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h00000000;
    else if (setup && !pwrite)
      prdata_r <= {24'h000000, rd_mux};
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  reserved_zero_a: assert property (ident_rd |-> prdata[5:4] == 2'h0)
    else $error("reserved identification bits not zero");
  fifo_flags_a: assert property (ident_rd |-> prdata[7:6] == {2{$past(fifo_en_r)}})
    else $error("fifo enabled bits wrong");
  line_prio_a: assert property (ier_r[2] && err_r != 4'h0 |-> ident_now[3:0] == 4'h6)
    else $error("line status not top priority");
  timeout_cause_a: assert property ($rose(to_r) |-> $past(rx_cnt_r) != '0 && fifo_en_r)
    else $error("time-out without data");
  lsr_clear_a: assert property (lsr_rd && !rx_valid |=> err_r == 4'h0)
    else $error("line status not cleared by read");
  fifo_off_a: assert property (setup_wr && !pwdata[0] |=> tx_cnt_r == '0 && rx_cnt_r == '0)
    else $error("fifos not discarded");
  rx_clear_a: assert property (setup_wr && pwdata[1] |=> rx_cnt_r == '0)
    else $error("receive fifo not cleared");
  tx_clear_a: assert property (setup_wr && pwdata[2] |=> tx_cnt_r == '0 ##1 thre_r)
    else $error("transmit fifo not cleared");
  data_level_a: assert property (ier_r == 4'h1 && fifo_en_r && rx_cnt_r >= trig_bytes(trig_r)
                                 |-> ident_now[3:0] == 4'h4)
    else $error("trigger level not reported");
  pend_bit_a: assert property (irq_pending == (ident_now[0] == 1'b0))
    else $error("pending bit wrong");
  ident_hold_a: assert property (ident_rd |-> prdata[7:0] == $past(ident_now))
    else $error("identification changed during read");

  timeout_c: cover property ($rose(to_r));
  overrun_c: cover property (overrun);
  thre_clear_c: cover property (ident_rd && prdata_r[3:0] == 4'h2);
  trig14_c: cover property (trig_r == 2'h3 && rda_lvl);
endmodule

// ===== tb/uart_peer.sv
module uart_peer (
  input  wire logic pclk,
  output logic      rxd,
  input  wire logic txd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd = 1'b1;
  // ****************
  // serial peer
  // ****************
  task automatic line(input logic v, input int n);
    repeat (n) @(posedge pclk) rxd <= v;
  endtask
  task automatic send(input logic [7:0] d, input int nb, input logic pen, ev, bad);
    line(1'b0, 16);
    for (int i = 0; i < nb; i++)
      line(d[i], 16);
    if (pen)
      line(^(d & ((8'h01 << nb) - 8'h01)) ^ ~ev ^ bad, 16);
    line(1'b1, 32);
  endtask
  task automatic recv(input int nb, input logic pen, output logic [7:0] d, output logic p);
    d = 8'h00;
    p = 1'b0;
    @(negedge txd);
    repeat (8) @(negedge pclk);
    for (int i = 0; i < nb; i++)
    begin
      repeat (16) @(negedge pclk);
      d[i] = txd;
    end
    if (pen)
    begin
      repeat (16) @(negedge pclk);
      p = txd;
    end
  endtask
  // high run after a zero frame
  task automatic stop_run(output int n);
    n = 0;
    @(negedge txd);
    @(posedge txd);
    @(negedge pclk);
    while (txd === 1'b1)
    begin
      n++;
      @(negedge pclk);
    end
  endtask
endmodule

// ===== tb/tb_uart_irq_fifo_line_format.sv
module tb_uart_irq_fifo_line_format;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, rxd, txd, pready, pslverr;
  logic        modem_change, irq_pending, pb;
  logic [4:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  rdv, d;
  int          num_errors, cmp_count, n;

  uart_irq_fifo_line_format #(.FIFO_DEPTH(16)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .modem_change(modem_change), .modem_status(8'h5A),
    .irq_pending(irq_pending));
  uart_peer peer (.pclk(pclk), .rxd(rxd), .txd(txd));

  always #50 pclk = ~pclk;
  // ****************
  // bus and compare
  // ****************
  task automatic apb(input logic w, input logic [2:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdv = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [2:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(nm, e, rdv);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    rchk("format", 3'h3, 8'h00);
    rchk("ident", 3'h2, 8'h01);
    rchk("unmapped", 3'h7, 8'h00);
    chk("pending", 8'h00, {7'h00, irq_pending});
  endtask
  task automatic t_setup;
    apb(1'b1, 3'h2, 8'hFF);
    rchk("ident en", 3'h2, 8'hC1);
    apb(1'b1, 3'h2, 8'h00);
    rchk("ident off", 3'h2, 8'h01);
    apb(1'b1, 3'h2, 8'h09);
    rchk("ident dma", 3'h2, 8'hC1);
  endtask
  task automatic t_tx;
    logic [7:0] f;
    for (int wl = 0; wl < 4; wl++)
    begin
      f = {3'h0, wl[0], 1'b1, wl != 3, wl[1:0]};
      apb(1'b1, 3'h3, f);
      apb(1'b1, 3'h0, 8'hA5);
      peer.recv(wl + 5, 1'b1, d, pb);
      chk("tx data", 8'hA5 & ((8'h01 << (wl + 5)) - 8'h01), d);
      chk("tx parity", {7'h00, ^d ^ ~f[4]}, {7'h00, pb});
      apb(1'b1, 3'h3, f | 8'h10);
      apb(1'b1, 3'h0, 8'h00);
      apb(1'b1, 3'h0, 8'h00);
      peer.stop_run(n);
      // stop period plus one reload cycle before the queued start
      chk("stop len", wl == 3 ? 8'h11 : wl == 0 ? 8'h19 : 8'h21, n[7:0]);
      repeat (300) @(posedge pclk);
    end
  endtask
  task automatic t_rx;
    for (int wl = 0; wl < 4; wl++)
    begin
      apb(1'b1, 3'h3, {3'h0, wl[1], 1'b1, 1'b0, wl[1:0]});
      apb(1'b1, 3'h1, 8'h05);
      peer.send(8'h5C, wl + 5, 1'b1, wl[1], 1'b0);
      rchk("rx avail", 3'h2, 8'hC4);
      rchk("rx data", 3'h0, 8'h5C & ((8'h01 << (wl + 5)) - 8'h01));
      rchk("rx none", 3'h2, 8'hC1);
      peer.send(8'h5C, wl + 5, 1'b1, wl[1], 1'b1);
      rchk("rx line", 3'h2, 8'hC6);
      apb(1'b0, 3'h5, 8'h00);
      chk("parity err", 8'h04, rdv & 8'h04);
      rchk("after lsr", 3'h2, 8'hC4);
      apb(1'b0, 3'h0, 8'h00);
    end
  endtask
  task automatic t_timeout;
    apb(1'b1, 3'h3, 8'h03);
    apb(1'b1, 3'h2, 8'h41);
    peer.send(8'h3A, 8, 1'b0, 1'b0, 1'b0);
    repeat (540) @(posedge pclk);
    rchk("below trig", 3'h2, 8'hC1);
    repeat (100) @(posedge pclk);
    rchk("timeout", 3'h2, 8'hCC);
    chk("pending", 8'h01, {7'h00, irq_pending});
    rchk("to data", 3'h0, 8'h3A);
    rchk("to clear", 3'h2, 8'hC1);
  endtask
  task automatic t_clear;
    apb(1'b1, 3'h2, 8'h01);
    peer.send(8'h81, 8, 1'b0, 1'b0, 1'b0);
    rchk("before clr", 3'h2, 8'hC4);
    apb(1'b1, 3'h2, 8'h03);
    rchk("rx cleared", 3'h2, 8'hC1);
    apb(1'b0, 3'h5, 8'h00);
    chk("ready bit", 8'h00, rdv & 8'h01);
    apb(1'b1, 3'h1, 8'h02);
    rchk("thre", 3'h2, 8'hC2);
    rchk("thre read", 3'h2, 8'hC1);
    // peer listens before the first start bit goes out
    fork
      peer.recv(8, 1'b0, d, pb);
      begin
        apb(1'b1, 3'h0, 8'h55);
        apb(1'b1, 3'h0, 8'hAA);
        apb(1'b1, 3'h2, 8'h05);
      end
    join
    chk("shift kept", 8'h55, d);
    rchk("tx cleared", 3'h2, 8'hC2);
    repeat (120) @(posedge pclk);
    apb(1'b0, 3'h5, 8'h00);
    chk("tx empty", 8'h40, rdv & 8'h40);
    apb(1'b1, 3'h1, 8'h00);
  endtask
  task automatic t_modem;
    apb(1'b1, 3'h1, 8'h0A);
    @(posedge pclk) modem_change <= 1'b1;
    @(posedge pclk) modem_change <= 1'b0;
    rchk("thre first", 3'h2, 8'hC2);
    rchk("modem", 3'h2, 8'hC0);
    rchk("status", 3'h6, 8'h5A);
    rchk("modem clr", 3'h2, 8'hC1);
  endtask
  task automatic t_divisor_latch_access;
    apb(1'b1, 3'h3, 8'h83);
    rchk("div low", 3'h0, 8'h01);
    rchk("div high", 3'h1, 8'h00);
    rchk("ident divisor_latch_access", 3'h2, 8'hC1);
    apb(1'b1, 3'h3, 8'h03);
    rchk("ier back", 3'h1, 8'h0A);
  endtask
  task automatic complete_run;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 5'h00;
    pwdata = 32'h00000000;
    modem_change = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_setup;
    t_tx;
    t_rx;
    t_timeout;
    t_clear;
    t_modem;
    t_divisor_latch_access;
    complete_run;
  end
  initial
  begin
    repeat (40000) @(posedge pclk);
    num_errors++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    complete_run;
  end
endmodule
